// ---- rtl/isrd_top.sv ----
// stats-path resizer with defect correction, fifo and apb registers
//
// The implementer's own choices: the placing of the registers and the APB register port.

////////////////////////////////////////////////////////////////////////////////
module isrd_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// fill side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// drain side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0]    level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [$clog2(DEPTH+1)-1:0] FULL_LVL = ($clog2(DEPTH+1))'(DEPTH);
	logic [WIDTH-1:0]             mem_q [DEPTH];
	logic [AW-1:0]                wr_q;
	logic [AW-1:0]                rd_q;
	logic [$clog2(DEPTH+1)-1:0]   cnt_q;
	wire                          push;
	wire                          pop;

	assign in_ready  = cnt_q != FULL_LVL;
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + ($clog2(DEPTH+1))'(push) - ($clog2(DEPTH+1))'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module isrd_top
	import isrd_pkg::*;
#(
	parameter int PIX_W = ISRD_PIX_W,
	parameter int DEPTH = ISRD_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// pixel input
	input  wire logic              pix_valid,
	output logic                   pix_ready,
	input  wire logic [PIX_W-1:0]  pix_data,
	input  wire logic              pix_from_mem,
	input  wire logic              line_sync,
	input  wire logic              frame_sync,
	// toward the statistics engine
	output logic                   stat_valid,
	input  wire logic              stat_ready,
	output logic [PIX_W-1:0]       stat_data,
	output logic                   stat_line_first
);
	localparam int LW = $clog2(DEPTH + 1);
	localparam logic [LW-1:0] READY_LVL = LW'(DEPTH - 3);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic              defect_corr_on_q;
	logic [11:0]       defect_limit_q;
	logic              subsample_on_q;
	logic              smoothing_on_q;
	logic [6:0]        resize_divisor_q;
	logic [12:0]       resize_start_offset_q;
	logic              line_sync_polarity_q;
	logic              realign_q;
	logic [31:0]       prdata_q;
	logic              pready_q;
	logic              pslverr_q;
	logic [12:0]       col_q;
	logic [LW-1:0]     level;

	wire acc_ph   = psel && penable && !pready_q;
	wire done     = psel && penable && pready_q;
	wire hit_def  = paddr == ISRD_OFS_DEFECT;
	wire hit_rsz  = paddr == ISRD_OFS_RESIZE;
	wire hit_st   = paddr == ISRD_OFS_START;
	wire hit_cfg  = paddr == ISRD_OFS_CFG;
	wire hit_stat = paddr == ISRD_OFS_STATUS;
	wire mapped   = hit_def || hit_rsz || hit_st || hit_cfg || hit_stat;
	wire wr_en    = done && pwrite;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_def) begin
			rd_mux[ISRD_DEFECT_ON_BIT]  = defect_corr_on_q;
			rd_mux[ISRD_LIMIT_MSB:0]    = defect_limit_q;
		end else if (hit_rsz) begin
			rd_mux[ISRD_SUBSAMPLE_BIT]  = subsample_on_q;
			rd_mux[ISRD_SMOOTH_BIT]     = smoothing_on_q;
			rd_mux[ISRD_DIVISOR_MSB:0]  = resize_divisor_q;
		end else if (hit_st) begin
			rd_mux[ISRD_START_MSB:0]    = resize_start_offset_q;
		end else if (hit_cfg) begin
			rd_mux[ISRD_POLARITY_BIT]   = line_sync_polarity_q;
		end else if (hit_stat) begin
			rd_mux[12:0]                = col_q;
			rd_mux[ISRD_STAT_LEVEL_LSB +: LW] = level;
		end
	end

	// reserved bits are not stored, so stray ones are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			defect_corr_on_q      <= 1'b0;
			defect_limit_q        <= ISRD_LIMIT_RST;
			subsample_on_q        <= 1'b0;
			smoothing_on_q        <= 1'b0;
			resize_divisor_q      <= ISRD_DIVISOR_RST;
			resize_start_offset_q <= ISRD_START_RST;
			line_sync_polarity_q  <= 1'b0;
			realign_q             <= 1'b0;
		end else begin
			realign_q <= wr_en && hit_st && pwdata[ISRD_REALIGN_BIT];
			if (wr_en && hit_def) begin
				defect_corr_on_q <= pwdata[ISRD_DEFECT_ON_BIT];
				defect_limit_q   <= pwdata[ISRD_LIMIT_MSB:0];
			end
			if (wr_en && hit_rsz) begin
				subsample_on_q   <= pwdata[ISRD_SUBSAMPLE_BIT];
				smoothing_on_q   <= pwdata[ISRD_SMOOTH_BIT];
				resize_divisor_q <= pwdata[ISRD_DIVISOR_MSB:0];
			end
			if (wr_en && hit_st) begin
				resize_start_offset_q <= pwdata[ISRD_START_MSB:0];
			end
			if (wr_en && hit_cfg) begin
				line_sync_polarity_q <= pwdata[ISRD_POLARITY_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc_ph;
			pslverr_q <= acc_ph && !mapped;
			prdata_q  <= (acc_ph && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// line sync and pixel window
	logic              ls_prev_q;
	logic              fs_prev_q;
	logic              pix_ready_q;
	logic [PIX_W-1:0]  cur_q;
	logic [PIX_W-1:0]  left_q;
	logic              cur_mem_q;
	logic              have_q;
	logic              first_q;
	logic [7:0]        acc_q;

	wire ls_act    = line_sync ^ line_sync_polarity_q;
	wire line_go   = ls_act && !ls_prev_q;
	wire frame_go  = frame_sync && !fs_prev_q;
	wire take      = pix_valid && pix_ready_q;
	wire emit      = have_q && (take || line_go);
	// neighbours replicate the edge sample at both ends of a line
	wire [PIX_W-1:0] nb_l = first_q ? cur_q : left_q;
	wire [PIX_W-1:0] nb_r = line_go ? cur_q : pix_data;

	// defect check against the two neighbours
	wire [PIX_W-1:0] nb_max = (nb_l > nb_r) ? nb_l : nb_r;
	wire [PIX_W-1:0] nb_min = (nb_l > nb_r) ? nb_r : nb_l;
	wire [PIX_W:0]   hi_lim = {1'b0, nb_max} + {1'b0, defect_limit_q};
	wire [PIX_W:0]   lo_sum = {1'b0, cur_q} + {1'b0, defect_limit_q};
	wire             is_bad = ({1'b0, cur_q} > hi_lim) || (lo_sum < {1'b0, nb_min});
	wire [PIX_W:0]   nb_avg = {1'b0, nb_l} + {1'b0, nb_r};
	wire             fix    = defect_corr_on_q && cur_mem_q && is_bad;
	wire [PIX_W-1:0] ctr    = fix ? nb_avg[PIX_W:1] : cur_q;

	// (1,2,1) smoothing
	wire [PIX_W+1:0] tap_sum = {2'b00, nb_l} + {1'b0, ctr, 1'b0} + {2'b00, nb_r};
	wire [PIX_W-1:0] smooth  = tap_sum[PIX_W+1:2];
	wire [PIX_W-1:0] out_pix = smoothing_on_q ? smooth : ctr;

	// phase accumulator: one output per divisor/16 inputs
	wire [7:0] acc_nx  = acc_q + ISRD_PHASE_STEP;
	wire [7:0] div8    = {1'b0, resize_divisor_q};
	wire       acc_hit = acc_nx >= div8;
	wire       in_win  = col_q >= resize_start_offset_q;
	wire       keep    = in_win && (!subsample_on_q || acc_hit);
	wire       first_o = col_q == resize_start_offset_q;
	wire       fifo_push = emit && keep;

	always_ff @(posedge clk) begin
		if (rst) begin
			ls_prev_q   <= 1'b0;
			fs_prev_q   <= 1'b0;
			pix_ready_q <= 1'b0;
			cur_q       <= '0;
			left_q      <= '0;
			cur_mem_q   <= 1'b0;
			have_q      <= 1'b0;
			first_q     <= 1'b0;
			col_q       <= 13'h0000;
			acc_q       <= 8'h00;
		end else begin
			ls_prev_q   <= ls_act;
			fs_prev_q   <= frame_sync;
			pix_ready_q <= level <= READY_LVL;
			if (take) begin
				left_q    <= cur_q;
				cur_q     <= pix_data;
				cur_mem_q <= pix_from_mem;
				have_q    <= 1'b1;
				first_q   <= line_go || !have_q;
			end else if (line_go) begin
				have_q <= 1'b0;
			end
			if (realign_q) begin
				col_q <= resize_start_offset_q;
				acc_q <= 8'h00;
			end else if (line_go || frame_go) begin
				col_q <= 13'h0000;
				acc_q <= 8'h00;
			end else if (emit) begin
				col_q <= col_q + 13'h0001;
				if (in_win && subsample_on_q) begin
					acc_q <= acc_hit ? acc_nx - div8 : acc_nx;
				end
			end
		end
	end

	assign pix_ready = pix_ready_q;

	////////////////////////////////////////////////////////////////////////////
	// buffer and output stage
	logic              f_valid;
	logic [PIX_W:0]    f_data;
	logic              stat_valid_q;
	logic [PIX_W-1:0]  stat_data_q;
	logic              stat_first_q;
	wire               f_ready = !stat_valid_q || stat_ready;

	isrd_fifo #(
		.WIDTH (PIX_W + 1),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (fifo_push),
		.in_ready  (),
		.in_data   ({first_o, out_pix}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data),
		.level     (level)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_valid_q <= 1'b0;
			stat_data_q  <= '0;
			stat_first_q <= 1'b0;
		end else if (f_ready) begin
			stat_valid_q <= f_valid;
			stat_data_q  <= f_data[PIX_W-1:0];
			stat_first_q <= f_valid && f_data[PIX_W];
		end
	end

	assign stat_valid      = stat_valid_q;
	assign stat_data       = stat_data_q;
	assign stat_line_first = stat_first_q;
endmodule

// ---- rtl/isrd_pkg.sv ----
// constants of the stats-path resizer and defect correction block
package isrd_pkg;
	// register byte offsets
	localparam logic [11:0] ISRD_OFS_DEFECT  = 12'h000;
	localparam logic [11:0] ISRD_OFS_RESIZE  = 12'h004;
	localparam logic [11:0] ISRD_OFS_START   = 12'h008;
	localparam logic [11:0] ISRD_OFS_CFG     = 12'h00c;
	localparam logic [11:0] ISRD_OFS_STATUS  = 12'h010;
	// field positions
	localparam int ISRD_DEFECT_ON_BIT   = 12;
	localparam int ISRD_LIMIT_MSB       = 11;
	localparam int ISRD_SUBSAMPLE_BIT   = 9;
	localparam int ISRD_SMOOTH_BIT      = 8;
	localparam int ISRD_DIVISOR_MSB     = 6;
	localparam int ISRD_REALIGN_BIT     = 13;
	localparam int ISRD_START_MSB       = 12;
	localparam int ISRD_POLARITY_BIT    = 0;
	localparam int ISRD_STAT_LEVEL_LSB  = 16;
	// reset values
	localparam logic [11:0] ISRD_LIMIT_RST   = 12'h000;
	localparam logic [6:0]  ISRD_DIVISOR_RST = 7'h10;
	localparam logic [12:0] ISRD_START_RST   = 13'h0000;
	// one step of the phase accumulator, in sixteenths
	localparam logic [7:0]  ISRD_PHASE_STEP  = 8'h10;
	localparam int ISRD_PIX_W      = 12;
	localparam int ISRD_FIFO_DEPTH = 16;
endpackage

// ---- testbench/isrd_top_properties.sv ----
// assertions on the resizer block's ports
module isrd_top_properties #(
	parameter int PIX_W = 12
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// register bus
	input wire logic             psel,
	input wire logic             penable,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	// pixel streams
	input wire logic             pix_ready,
	input wire logic             stat_valid,
	input wire logic             stat_ready,
	input wire logic [PIX_W-1:0] stat_data,
	input wire logic             stat_line_first
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence access_wait_s;
		psel && penable && !pready;
	endsequence
	////////////////////////////////////////
	apb_wait_a: assert property (access_wait_s |=> pready) else $error("no answer after wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	ready_cause_a: assert property (pready |-> $past(psel && penable, 1))
		else $error("pready without access");
	error_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	stat_hold_a: assert property (stat_valid && !stat_ready |=> stat_valid
		&& $stable(stat_data) && $stable(stat_line_first)) else $error("stalled word changed");
	first_valid_a: assert property (stat_line_first |-> stat_valid)
		else $error("line mark without data");
	release_idle_a: assert property ($fell(rst) |-> !pix_ready && !stat_valid)
		else $error("outputs active after reset");
endmodule

// ---- testbench/isrd_stat_sink.sv ----
// statistics engine model taking the resized stream
module isrd_stat_sink (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// resized stream and stall request
	input wire logic        stat_valid,
	output logic            stat_ready,
	input wire logic [11:0] stat_data,
	input wire logic        stat_line_first,
	input wire logic        hold
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] got [$];
	////////////////////////////////////////
	always @(posedge clk) begin
		stat_ready <= !rst && !hold;
		if (!rst && stat_valid && stat_ready)
			got.push_back({stat_line_first, stat_data});
	end
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the stats-path resizer block
module tb_top import isrd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, pol = 0;
	logic pix_valid = 0, pix_ready, pix_from_mem = 0, line_sync = 0, frame_sync = 0, hold = 0;
	logic stat_valid, stat_ready, stat_line_first;
	logic [11:0] paddr = '0, pix_data = '0, stat_data, pix [32];
	logic [31:0] pwdata = '0, prdata, rd;
	logic [11:0] ra [4] = '{ISRD_OFS_DEFECT, ISRD_OFS_RESIZE, ISRD_OFS_START, ISRD_OFS_CFG};
	logic [31:0] rv [4] = '{32'h0, 32'h10, 32'h0, 32'h0};
	logic [31:0] wv [3] = '{32'h1abc, 32'h330, 32'h5};
	int error_cnt = 0, num_checks = 0, refused = 0, dv [3] = '{16, 32, 48};
	logic [12:0] exp_q [$];
	always #25 clk = ~clk;
	isrd_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pix_valid, .pix_ready, .pix_data, .pix_from_mem, .line_sync, .frame_sync,
		.stat_valid, .stat_ready, .stat_data, .stat_line_first);
	isrd_stat_sink i_sink (.clk, .rst, .stat_valid, .stat_ready, .stat_data, .stat_line_first,
		.hold);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		error_cnt += (n >= 50);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one line: expectation, pixels, flush, comparison
	task automatic run(input int n, input bit def, input int lim, input bit sm, input int ofs,
		input int dvs);
		int l, c, r, t;
		exp_q.delete();
		for (int i = 0; i < n; i++) begin
			l = pix[i == 0 ? 0 : i - 1];
			r = pix[i == n - 1 ? i : i + 1];
			c = pix[i];
			if (def && (c > (l > r ? l : r) + lim || c + lim < (l < r ? l : r)))
				c = (l + r) / 2;
			if (sm)
				c = (l + 2 * c + r) / 4;
			// kept where the sixteenths count crosses a divisor multiple
			if (i >= ofs && (i - ofs + 1) * 16 / dvs != (i - ofs) * 16 / dvs)
				exp_q.push_back({i == ofs, 12'(c)});
		end
		for (int i = 0; i < n; i++) begin
			pix_valid <= 1;
			pix_data <= pix[i];
			t = 0;
			do begin
				@(posedge clk);
				t++;
				refused += (pix_ready !== 1'b1);
			end while (pix_ready !== 1'b1 && t < 500);
		end
		pix_valid <= 0;
		@(posedge clk);
		line_sync <= ~pol;
		@(posedge clk);
		line_sync <= pol;
		t = 0;
		while (i_sink.got.size() < exp_q.size() && t++ < 400)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk(i_sink.got.size(), exp_q.size());
		foreach (exp_q[i])
			chk(i_sink.got[i], exp_q[i]);
		i_sink.got.delete();
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 4; i++) begin
			apb(0, ra[i], 0);
			chk(rd, rv[i]);
		end
		for (int i = 0; i < 3; i++) begin
			apb(1, ra[i], wv[i]);
			apb(0, ra[i], 0);
			chk(rd, wv[i]);
		end
		apb(0, 12'h040, 0);
		chk(er, 1);
		chk(rd, 0);
		apb(1, ISRD_OFS_DEFECT, 0);
		apb(1, ISRD_OFS_RESIZE, 32'h10);
		apb(1, ISRD_OFS_START, 0);
		run(0, 0, 0, 0, 0, 16);
		for (int i = 0; i < 32; i++)
			pix[i] = 12'(4 * (25 + i * 7 % 13));
		run(8, 0, 0, 0, 0, 16);
		apb(1, ISRD_OFS_RESIZE, 32'h110);
		run(8, 0, 0, 1, 0, 16);
		apb(1, ISRD_OFS_RESIZE, 32'h10);
		apb(1, ISRD_OFS_START, 2);
		run(10, 0, 0, 0, 2, 16);
		apb(1, ISRD_OFS_START, 32'h2003);
		apb(0, ISRD_OFS_STATUS, 0);
		chk(rd, 3);
		run(10, 0, 0, 0, 0, 16);
		apb(1, ISRD_OFS_START, 32'h2003);
		@(posedge clk);
		frame_sync <= 1;
		@(posedge clk);
		frame_sync <= 0;
		run(10, 0, 0, 0, 3, 16);
		apb(1, ISRD_OFS_START, 0);
		foreach (dv[i]) begin
			apb(1, ISRD_OFS_RESIZE, 32'h200 | dv[i]);
			run(12, 0, 0, 0, 0, dv[i]);
		end
		apb(1, ISRD_OFS_RESIZE, 32'h10);
		pix = '{default: 12'h064};
		pix[3] = 12'h384;
		for (int k = 0; k < 3; k++) begin
			apb(1, ISRD_OFS_DEFECT, k == 2 ? 32'h32 : 32'h1032);
			pix_from_mem <= k != 1;
			run(8, k == 0, 50, 0, 0, 16);
		end
		pol = 1;
		apb(1, ISRD_OFS_CFG, 1);
		line_sync <= 1;
		run(0, 0, 0, 0, 0, 16);
		run(8, 0, 0, 0, 0, 16);
		refused = 0;
		hold <= 1;
		fork
			run(20, 0, 0, 0, 0, 16);
			begin
				repeat (80) @(posedge clk);
				chk(refused > 0, 1);
				hold <= 0;
			end
		join
		final_report();
	end
endmodule
bind isrd_top isrd_top_properties #(.PIX_W(PIX_W)) i_props (.clk, .rst, .psel, .penable,
	.prdata, .pready, .pslverr, .pix_ready, .stat_valid, .stat_ready, .stat_data,
	.stat_line_first);
